// File: hw/cbccd_pkg.sv
// Package for the branch, call and clear slice of the 8-bit core.
// Assumes a single 100 MHz clock and an Avalon-MM register slave at the top.
package cbccd_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int PC_W        = 21;
  localparam int DADDR_W     = 12;
  localparam int STACK_DEPTH = 31;
  localparam int PTR_W       = 5;

  // ---------------------------------------------------------------
  // Instruction phases within one instruction cycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CBCCD_Q1,
    CBCCD_Q2,
    CBCCD_Q3,
    CBCCD_Q4
  } cbccd_phase_t;

  // ---------------------------------------------------------------
  // Opcode patterns
  // ---------------------------------------------------------------
  localparam logic [3:0]  OP_BIT_TOGGLE  = 4'h7;    // Bits 15:12.
  localparam logic [7:0]  OP_BR_OVERFLOW = 8'hE4;   // Bits 15:8.
  localparam logic [7:0]  OP_BR_ZERO     = 8'hE0;   // Bits 15:8.
  localparam logic [6:0]  OP_CALL        = 7'h76;   // Bits 15:9.
  localparam logic [3:0]  OP_CALL_WORD2  = 4'hF;    // Bits 15:12 of second word.
  localparam logic [6:0]  OP_CLEAR_FILE  = 7'h35;   // Bits 15:9.
  localparam logic [15:0] OP_CLEAR_WDOG  = 16'h0004;
  localparam logic [15:0] OP_NOP         = 16'h0000;

  // ---------------------------------------------------------------
  // Status bit positions and reset values
  // ---------------------------------------------------------------
  localparam int          ST_ZERO  = 2;
  localparam int          ST_OVF   = 3;
  localparam logic [4:0]  ST_RESET = 5'h00;
  localparam logic [20:0] PC_STEP  = 21'h000002;
  localparam logic [20:0] PC_RESET = 21'h000000;

  // ---------------------------------------------------------------
  // Watchdog counter and postscaler
  // ---------------------------------------------------------------
  localparam logic [7:0] WDT_CNT_MAX  = 8'hFF;
  localparam logic [6:0] WDT_POST_MAX = 7'h7F;

  // ---------------------------------------------------------------
  // Register byte offsets and field positions
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_WORK   = 6'h04;
  localparam logic [5:0] REG_FLAGS  = 6'h08;
  localparam logic [5:0] REG_BANK   = 6'h0C;
  localparam logic [5:0] REG_PCNT   = 6'h10;
  localparam logic [5:0] REG_SHADOW = 6'h14;
  localparam logic [5:0] REG_STACK  = 6'h18;
  localparam logic [5:0] REG_WDOG   = 6'h1C;
  localparam int CTRL_RUN   = 0;
  localparam int SHD_FLAGS  = 8;
  localparam int SHD_BANK   = 16;
  localparam int STK_PTR    = 24;
  localparam int STK_FULL   = 31;
  localparam int WDG_POST   = 8;
  localparam int WDG_PDOWN  = 16;
  localparam int WDG_TOUT   = 17;

endpackage : cbccd_pkg

// File: hw/cbccd_phase.sv
// Four-phase sequencer: one phase per clock while the core runs.
// Assumes run comes from a register on the same clock.
`timescale 1ns/10ps
module cbccd_phase (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                run,
  output cbccd_pkg::cbccd_phase_t  phase
);

  cbccd_pkg::cbccd_phase_t phase_q;
  cbccd_pkg::cbccd_phase_t phase_d;

  // Advance one phase per enabled clock; a stopped core freezes in place.
  always_comb begin
    phase_d = phase_q;
    if (run) begin
      case (phase_q)
        cbccd_pkg::CBCCD_Q1: phase_d = cbccd_pkg::CBCCD_Q2;
        cbccd_pkg::CBCCD_Q2: phase_d = cbccd_pkg::CBCCD_Q3;
        cbccd_pkg::CBCCD_Q3: phase_d = cbccd_pkg::CBCCD_Q4;
        cbccd_pkg::CBCCD_Q4: phase_d = cbccd_pkg::CBCCD_Q1;
        default:             phase_d = cbccd_pkg::CBCCD_Q1;
      endcase
    end
  end

  // Register the phase.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_q <= cbccd_pkg::CBCCD_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;

endmodule : cbccd_phase

// File: hw/cbccd_stack.sv
// Hardware return stack, push only; the top entry is visible for reads.
// Assumes push is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
module cbccd_stack (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        push,
  input  wire logic [20:0] push_data,
  output logic      [20:0] return_stack_top,
  output logic      [4:0]  depth,
  output logic             full
);

  logic [20:0] mem_q [cbccd_pkg::STACK_DEPTH];
  logic [4:0]  ptr_q;
  logic [4:0]  ptr_d;
  logic        full_q;
  logic        full_d;
  logic        wr_en;

  // A push onto a full stack is dropped and leaves a sticky flag, so a
  // runaway call chain cannot overwrite the oldest return address.
  always_comb begin
    ptr_d  = ptr_q;
    full_d = full_q;
    wr_en  = 1'b0;
    if (push) begin
      if (ptr_q < 5'(cbccd_pkg::STACK_DEPTH)) begin
        wr_en = 1'b1;
        ptr_d = ptr_q + 5'h01;
      end else begin
        full_d = 1'b1;
      end
    end
  end

  // Register pointer, flag and storage.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ptr_q  <= 5'h00;
      full_q <= 1'b0;
    end else begin
      ptr_q  <= ptr_d;
      full_q <= full_d;
    end
    if (wr_en) begin
      mem_q[ptr_q] <= push_data;
    end
  end

  assign return_stack_top   = (ptr_q == 5'h00) ? 21'h000000 : mem_q[ptr_q - 5'h01];
  assign depth = ptr_q;
  assign full  = full_q;

endmodule : cbccd_stack

// File: hw/cbccd_top.sv
// Decode and execute logic for toggle, relative branches, call, clear and
// watchdog clear, with an Avalon-MM slave for the core's working state.
// Assumes program and data memories on the same clock that answer within
// the cycle in which their address register is presented.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// Contract
// - Bit toggle reads the byte, inverts the selected bit, writes back, flags untouched.
// - Overflow branch goes only when overflow set; one cycle, two when taken.
// - Taken branch target is incremented counter plus twice the signed offset.
// - Zero branch goes only when zero set, same timing, no flag changes.
// - Call is two words: opcode, shadow bit, low target; then ones and high target.
// - Call pushes the address after both call words onto the return stack.
// - Shadow bit set copies work, flags and bank select into their shadows.
// - Call loads the 20-bit target into counter bits 20 to 1.
// - Call takes two cycles: push in third phase, load in fourth, then idle.
// - Clear file writes zero to the register and sets the zero flag.
// - Access bit zero selects access bank; one selects the bank register.
// - Clear watchdog zeroes counter and postscaler, sets timeout and powerdown flags.
module cbccd_top (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [20:0] prog_addr,
  input  wire logic [15:0] prog_word,
  output logic      [11:0] dmem_addr,
  output logic             dmem_rd,
  input  wire logic [7:0]  dmem_rdata,
  output logic             dmem_we,
  output logic      [7:0]  dmem_wdata
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Twice the signed 8-bit offset, widened to the counter.
  function automatic logic [20:0] rel_offset(input logic [7:0] n);
    rel_offset = {{12{n[7]}}, n, 1'b0};
  endfunction : rel_offset

  // Access bank maps low half to bank 0 and high half to bank 15.
  function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] f,
                                            input logic [3:0] bank_select_reg);
    bank_addr = a ? {bank_select_reg, f} : {{4{f[7]}}, f};
  endfunction : bank_addr

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction : bit_mask

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cbccd_pkg::cbccd_phase_t ph;
  logic        run_q,  run_d;
  logic [20:0] pc_q,   pc_d;
  logic [15:0] ir_q,   ir_d;
  logic        flush_q, flush_d;
  logic [7:0]  w_q,    w_d;
  logic [4:0]  st_q,   st_d;
  logic [3:0]  bsr_q,  bsr_d;
  logic [7:0]  ws_q,   ws_d;
  logic [4:0]  ss_q,   ss_d;
  logic [3:0]  bank_select_shadow_q, bank_select_shadow_d;
  logic [7:0]  dat_q,  dat_d;
  logic [11:0] daddr_q, daddr_d;
  logic        rd_q,   rd_d;
  logic        we_q,   we_d;
  logic [7:0]  wdat_q, wdat_d;
  logic [7:0]  wcnt_q, wcnt_d;
  logic [6:0]  wpost_q, wpost_d;
  logic        to_q,   to_d;
  logic        pd_q,   pd_d;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic        push;
  logic [20:0] push_data;
  logic [20:0] return_stack_top;
  logic [4:0]  depth;
  logic        stk_full;
  logic        bus_wr;
  logic        is_btg, is_bov, is_bz, is_call, is_clear_file_op, is_clear_watchdog_op;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  cbccd_phase u_phase (
    .ref_clk (ref_clk),
    .srst    (srst),
    .run     (run_q),
    .phase   (ph)
  );

  cbccd_stack u_stack (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .push      (push),
    .push_data (push_data),
    .return_stack_top       (return_stack_top),
    .depth     (depth),
    .full      (stk_full)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------

  // A lone second call word decodes as nothing and so runs as a no-op.
  assign is_btg    = ir_q[15:12] == cbccd_pkg::OP_BIT_TOGGLE;
  assign is_bov    = ir_q[15:8] == cbccd_pkg::OP_BR_OVERFLOW;
  assign is_bz     = ir_q[15:8] == cbccd_pkg::OP_BR_ZERO;
  assign is_call   = ir_q[15:9] == cbccd_pkg::OP_CALL;
  assign is_clear_file_op   = ir_q[15:9] == cbccd_pkg::OP_CLEAR_FILE;
  assign is_clear_watchdog_op = ir_q == cbccd_pkg::OP_CLEAR_WDOG;
  assign push_data = pc_q + cbccd_pkg::PC_STEP;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------

  // Every access waits exactly one cycle; the read word is captured on the
  // first cycle so it is stable at the completing edge.
  assign bus_wr = avs_write && !wait_q;

  always_comb begin
    wait_d  = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    if ((avs_read || avs_write) && wait_q) begin
      case (avs_address)
        cbccd_pkg::REG_CTRL:   rdata_d = {31'h00000000, run_q};
        cbccd_pkg::REG_WORK:   rdata_d = {24'h000000, w_q};
        cbccd_pkg::REG_FLAGS:  rdata_d = {27'h0000000, st_q};
        cbccd_pkg::REG_BANK:   rdata_d = {28'h0000000, bsr_q};
        cbccd_pkg::REG_PCNT:   rdata_d = {11'h000, pc_q};
        cbccd_pkg::REG_SHADOW: rdata_d = {12'h000, bank_select_shadow_q, 3'h0, ss_q, ws_q};
        cbccd_pkg::REG_STACK:  rdata_d = {stk_full, 2'h0, depth, 3'h0, return_stack_top};
        cbccd_pkg::REG_WDOG:   rdata_d = {14'h0000, to_q, pd_q, 1'h0, wpost_q, wcnt_q};
        default:               rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Core execution
  // ---------------------------------------------------------------

  // Software writes land first so that the core's own updates win when both
  // touch the same state in one cycle.
  always_comb begin
    run_d   = run_q;
    pc_d    = pc_q;
    ir_d    = ir_q;
    flush_d = flush_q;
    w_d     = w_q;
    st_d    = st_q;
    bsr_d   = bsr_q;
    ws_d    = ws_q;
    ss_d    = ss_q;
    bank_select_shadow_d  = bank_select_shadow_q;
    dat_d   = dat_q;
    daddr_d = daddr_q;
    rd_d    = 1'b0;
    we_d    = 1'b0;
    wdat_d  = wdat_q;
    wcnt_d  = wcnt_q;
    wpost_d = wpost_q;
    to_d    = to_q;
    pd_d    = pd_q;
    push    = 1'b0;
    if (bus_wr) begin
      case (avs_address)
        cbccd_pkg::REG_CTRL:  run_d = avs_writedata[cbccd_pkg::CTRL_RUN];
        cbccd_pkg::REG_WORK:  w_d   = avs_writedata[7:0];
        cbccd_pkg::REG_FLAGS: st_d  = avs_writedata[4:0];
        cbccd_pkg::REG_BANK:  bsr_d = avs_writedata[3:0];
        cbccd_pkg::REG_PCNT:  pc_d  = {avs_writedata[20:1], 1'b0};
        default: ;
      endcase
    end
    // Watchdog ticks once per instruction cycle; a postscaler wrap times out.
    if (run_q && ph == cbccd_pkg::CBCCD_Q4) begin
      wcnt_d = wcnt_q + 8'h01;
      if (wcnt_q == cbccd_pkg::WDT_CNT_MAX) begin
        wpost_d = wpost_q + 7'h01;
        if (wpost_q == cbccd_pkg::WDT_POST_MAX) begin
          to_d = 1'b0;
        end
      end
    end
    if (run_q) begin
      case (ph)
        // Fetch; the idle cycle of a two-cycle op fetches nothing.
        cbccd_pkg::CBCCD_Q1: begin
          if (flush_q) begin
            ir_d = cbccd_pkg::OP_NOP;
          end else begin
            ir_d = prog_word;
            pc_d = pc_q + cbccd_pkg::PC_STEP;
          end
        end
        // Read the file register.
        cbccd_pkg::CBCCD_Q2: begin
          if (is_btg) begin
            rd_d    = 1'b1;
            daddr_d = bank_addr(ir_q[0], ir_q[11:4], bsr_q);
          end else if (is_clear_file_op) begin
            rd_d    = 1'b1;
            daddr_d = bank_addr(ir_q[8], ir_q[7:0], bsr_q);
          end
        end
        // Process: latch read data, push the return address, save shadows.
        cbccd_pkg::CBCCD_Q3: begin
          dat_d = dmem_rdata;
          if (is_call) begin
            push = 1'b1;
            if (ir_q[8]) begin
              ws_d   = w_q;
              ss_d   = st_q;
              bank_select_shadow_d = bsr_q;
            end
          end
          if (is_clear_watchdog_op) begin
            wcnt_d  = 8'h00;
            wpost_d = 7'h00;
            to_d    = 1'b1;
            pd_d    = 1'b1;
          end
        end
        // Write back and redirect the counter.
        cbccd_pkg::CBCCD_Q4: begin
          flush_d = 1'b0;
          if (is_btg) begin
            we_d   = 1'b1;
            wdat_d = dat_q ^ bit_mask(ir_q[3:1]);
          end
          if (is_clear_file_op) begin
            we_d   = 1'b1;
            wdat_d = 8'h00;
            st_d[cbccd_pkg::ST_ZERO] = 1'b1;
          end
          if ((is_bov && st_q[cbccd_pkg::ST_OVF]) ||
              (is_bz && st_q[cbccd_pkg::ST_ZERO])) begin
            pc_d    = pc_q + rel_offset(ir_q[7:0]);
            flush_d = 1'b1;
          end
          if (is_call) begin
            // The second call word sits at the counter during this phase.
            pc_d    = {prog_word[11:0], ir_q[7:0], 1'b0};
            flush_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_q   <= 1'b0;
      pc_q    <= cbccd_pkg::PC_RESET;
      ir_q    <= cbccd_pkg::OP_NOP;
      flush_q <= 1'b0;
      w_q     <= 8'h00;
      st_q    <= cbccd_pkg::ST_RESET;
      bsr_q   <= 4'h0;
      ws_q    <= 8'h00;
      ss_q    <= 5'h00;
      bank_select_shadow_q  <= 4'h0;
      dat_q   <= 8'h00;
      daddr_q <= 12'h000;
      rd_q    <= 1'b0;
      we_q    <= 1'b0;
      wdat_q  <= 8'h00;
      wcnt_q  <= 8'h00;
      wpost_q <= 7'h00;
      to_q    <= 1'b1;
      pd_q    <= 1'b1;
    end else begin
      run_q   <= run_d;
      pc_q    <= pc_d;
      ir_q    <= ir_d;
      flush_q <= flush_d;
      w_q     <= w_d;
      st_q    <= st_d;
      bsr_q   <= bsr_d;
      ws_q    <= ws_d;
      ss_q    <= ss_d;
      bank_select_shadow_q  <= bank_select_shadow_d;
      dat_q   <= dat_d;
      daddr_q <= daddr_d;
      rd_q    <= rd_d;
      we_q    <= we_d;
      wdat_q  <= wdat_d;
      wcnt_q  <= wcnt_d;
      wpost_q <= wpost_d;
      to_q    <= to_d;
      pd_q    <= pd_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign prog_addr       = pc_q;
  assign dmem_addr       = daddr_q;
  assign dmem_rd         = rd_q;
  assign dmem_we         = we_q;
  assign dmem_wdata      = wdat_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  btg_write_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q4 && is_btg) |=>
      (dmem_we && dmem_wdata == ($past(dat_q) ^ bit_mask($past(ir_q[3:1])))))
    else $error("toggle write-back value wrong");

  bov_taken_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q4 && is_bov && st_q[cbccd_pkg::ST_OVF]) |=>
      (flush_q && pc_q == $past(pc_q) + rel_offset($past(ir_q[7:0]))))
    else $error("taken overflow branch target wrong");

  bov_skip_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q4 && is_bov && !st_q[cbccd_pkg::ST_OVF]) |=>
      !flush_q)
    else $error("untaken overflow branch stalled");

  bz_flags_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q4 && is_bz && !bus_wr) |=>
      (st_q == $past(st_q) && flush_q == $past(st_q[cbccd_pkg::ST_ZERO])))
    else $error("zero branch flags or timing wrong");

  call_push_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q1 && !flush_q &&
     prog_word[15:9] == cbccd_pkg::OP_CALL && $stable(run_q)) ##1 run_q [*2] |->
      (push && push_data == $past(pc_q, 2) + 21'h000004))
    else $error("call pushed wrong return address");

  shadow_save_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q3 && is_call) |=>
      ($past(ir_q[8]) ? (ws_q == $past(w_q) && bank_select_shadow_q == $past(bsr_q) &&
                         ss_q == $past(st_q))
                      : (ws_q == $past(ws_q) && ss_q == $past(ss_q))))
    else $error("shadow update wrong");

  call_target_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q4 && is_call) |=>
      (flush_q && pc_q == {$past(prog_word[11:0]), $past(ir_q[7:0]), 1'b0})
      ##1 (!run_q || ir_q == cbccd_pkg::OP_NOP))
    else $error("call target or idle cycle wrong");

  clear_file_op_zero_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q4 && is_clear_file_op) |=>
      (dmem_we && dmem_wdata == 8'h00 && st_q[cbccd_pkg::ST_ZERO]))
    else $error("clear file did not write zero");

  bank_sel_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q2 && is_clear_file_op) |=>
      (dmem_rd && dmem_addr[7:0] == $past(ir_q[7:0]) &&
       dmem_addr[11:8] == ($past(ir_q[8]) ? $past(bsr_q) :
                           ($past(ir_q[7]) ? 4'hF : 4'h0))))
    else $error("bank selection wrong");

  wdog_clear_a: assert property (
    (run_q && ph == cbccd_pkg::CBCCD_Q3 && is_clear_watchdog_op) |=>
      (wcnt_q == 8'h00 && wpost_q == 7'h00 && to_q && pd_q))
    else $error("watchdog clear incomplete");

  phase_order_a: assert property (
    (dmem_rd |-> ph == cbccd_pkg::CBCCD_Q3) and
    (dmem_we |-> ph == cbccd_pkg::CBCCD_Q1))
    else $error("data access in wrong phase");

endmodule : cbccd_top

// File: tb/cbccd_mem.sv
// Program and data memory model facing the decode slice.
// Assumes registered address and strobe outputs on ref_clk.
`timescale 1ns/10ps
module cbccd_mem (
  input  wire logic        ref_clk,
  input  wire logic [20:0] prog_addr,
  output logic      [15:0] prog_word,
  input  wire logic [11:0] dmem_addr,
  input  wire logic        dmem_rd,
  output logic      [7:0]  dmem_rdata,
  input  wire logic        dmem_we,
  input  wire logic [7:0]  dmem_wdata
);
  logic [15:0] rom [0:1023];
  logic [7:0]  ram [0:4095];
  logic [7:0]  last_q = 8'h00;
  // Outside a strobe the bus shows the inverse of the last byte, so stale reads show up.
  assign prog_word  = rom[prog_addr[10:1]];
  assign dmem_rdata = dmem_rd ? ram[dmem_addr] : ~last_q;
  // A write lands at the edge that ends its strobe cycle.
  always @(posedge ref_clk) begin
    if (dmem_we) ram[dmem_addr] <= dmem_wdata;
    if (dmem_rd) last_q <= ram[dmem_addr];
  end
endmodule : cbccd_mem

// File: tb/cbccd_top_test.sv
// Self-checking bench for the branch, call and clear decode slice.
// Assumes the memory model answers within the strobe cycle.
`timescale 1ns/10ps
module cbccd_top_test;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [20:0] prog_addr;
  logic [15:0] prog_word;
  logic [11:0] dmem_addr;
  logic        dmem_rd;
  logic        dmem_we;
  logic [7:0]  dmem_rdata;
  logic [7:0]  dmem_wdata;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #5 ref_clk = ~ref_clk;

  cbccd_top cbccd_top_i (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .prog_addr, .prog_word,
    .dmem_addr, .dmem_rd, .dmem_rdata, .dmem_we, .dmem_wdata);
  cbccd_mem cbccd_mem_i (.ref_clk, .prog_addr, .prog_word, .dmem_addr, .dmem_rd,
    .dmem_rdata, .dmem_we, .dmem_wdata);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One Avalon access; the request holds until the edge that sees waitrequest low.
  // Waitrequest and read data are registered, so their value in the low half of
  // the clock is the one that the next rising edge samples, free of any race.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    do begin
      @(negedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    @(posedge ref_clk);
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // The whole run needs about 380 cycles; a hang is cut off well beyond that.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    for (int i = 0; i < 1024; i++) cbccd_mem_i.rom[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) cbccd_mem_i.ram[i] = 8'h00;
    cbccd_mem_i.rom[0]       = 16'h6A10; // Clear 0x010.
    cbccd_mem_i.rom[1]       = 16'h7208; // Toggle bit 4 of 0x020.
    cbccd_mem_i.rom[2]       = 16'hE002; // Zero branch over two words.
    cbccd_mem_i.rom[3]       = 16'h6A11;
    cbccd_mem_i.rom[4]       = 16'h6A11;
    cbccd_mem_i.rom[5]       = 16'hE401; // Overflow branch over one word.
    cbccd_mem_i.rom[6]       = 16'h7300; // Toggle bit 0 of 0x030.
    cbccd_mem_i.rom[7]       = 16'h0004; // Clear watchdog.
    cbccd_mem_i.rom[8]       = 16'hED34; // Call with shadow save.
    cbccd_mem_i.rom[9]       = 16'hF001;
    cbccd_mem_i.rom[10'h134] = 16'h7051;
    cbccd_mem_i.rom[10'h135] = 16'hE0FF;
    cbccd_mem_i.ram[12'h010] = 8'h5A;
    cbccd_mem_i.ram[12'h011] = 8'h77;
    cbccd_mem_i.ram[12'h020] = 8'h75;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 6'h1C, 32'h0);
    chk("wdog flags reset", 32'h30000, rd & 32'h30000); // Flags high.
    bus(1'b1, 6'h20, 32'hFFFF);
    bus(1'b0, 6'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 6'h14, 32'hFFFF);
    bus(1'b0, 6'h14, 32'h0);
    chk("shadow ro", 32'h0, rd); // Shadows idle before a call.
    bus(1'b1, 6'h04, 32'hA5);
    bus(1'b1, 6'h0C, 32'h3);
    bus(1'b1, 6'h08, 32'h0);
    $display("test registers done");
    bus(1'b1, 6'h00, 32'h1);
    repeat (200) @(posedge ref_clk);
    bus(1'b1, 6'h00, 32'h0);
    chk("cleared byte", 32'h00, 32'(cbccd_mem_i.ram[12'h010]));
    chk("toggled bit4", 32'h65, 32'(cbccd_mem_i.ram[12'h020]));
    chk("skipped byte", 32'h77, 32'(cbccd_mem_i.ram[12'h011]));
    chk("banked toggle", 32'h01, 32'(cbccd_mem_i.ram[12'h305]));
    chk("untaken next", 32'h01, 32'(cbccd_mem_i.ram[12'h030]));
    bus(1'b0, 6'h08, 32'h0);
    chk("flags", 32'h4, rd & 32'hC); // Zero set, overflow kept.
    bus(1'b0, 6'h14, 32'h0);
    chk("shadow", 32'h000304A5, rd & 32'h000F1FFF); // Saved on call.
    bus(1'b0, 6'h18, 32'h0);
    chk("stack", 32'h01000014, rd & 32'h9F1FFFFF); // Return address.
    bus(1'b0, 6'h1C, 32'h0);
    // The core ran 203 phases; 44 instruction cycles end after the clear.
    chk("wdog state", 32'h3002C, rd & 32'h37FFF); // Cleared, then counting.
    $display("test program done");
    // Second run from reset with overflow set: the overflow branch now skips.
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b1, 6'h08, 32'h8);
    bus(1'b1, 6'h00, 32'h1);
    repeat (100) @(posedge ref_clk);
    bus(1'b1, 6'h00, 32'h0);
    chk("taken skip", 32'h01, 32'(cbccd_mem_i.ram[12'h030]));
    bus(1'b0, 6'h08, 32'h0);
    chk("flags again", 32'hC, rd & 32'hC); // Overflow kept, zero set.
    $display("test overflow rerun done");
    give_verdict();
  end
endmodule : cbccd_top_test
